// ===== rtl/tkp_buf.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`include "tkp_cfg.svh"

module tkp_buf #(
    parameter int W = `TKP_WORD_W
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);

    if (W < 1) begin : g_bad_width
        $error("tkp_buf: width must be at least one bit.");
    end

    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic wr_ptr;
        logic rd_ptr;
        logic [1:0] count;
    } tkp_buf_s;

    tkp_buf_s st_ff;
    tkp_buf_s nxt_st;
    logic push;
    logic pop;

    // Full and empty come straight from the fill count, so neither side is misled.
    assign in_ready = (st_ff.count != 2'h2);
    assign out_valid = (st_ff.count != 2'h0);
    assign out_data = st_ff.mem[st_ff.rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointers advance on each accepted push and pop; the count steps only when one of them happens alone.
    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.mem[st_ff.wr_ptr] = in_data;
            nxt_st.wr_ptr = ~st_ff.wr_ptr;
        end
        if (pop) begin
            nxt_st.rd_ptr = ~st_ff.rd_ptr;
        end
        if (push && !pop) begin
            nxt_st.count = st_ff.count + 2'h1;
        end else if (pop && !push) begin
            nxt_st.count = st_ff.count - 2'h1;
        end
    end

    // State register.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

endmodule : tkp_buf

// ===== rtl/tkp_cfg.svh
// Constants of the timekeeper three-wire port: command fields, register map and reset values.
// Assumes inclusion by bare name from the port and buffer files.
`ifndef TKP_CFG_SVH
`define TKP_CFG_SVH

// ****************************************************************
// Command byte layout
// ****************************************************************
`define TKP_CMD_BITS 8
`define TKP_DIR_BIT 0
`define TKP_ADDR_LSB 1
`define TKP_ADDR_MSB 3
`define TKP_BURST_CODE 7'h5F
`define TKP_TEST_CODE 4'h9

// ****************************************************************
// Register map and reset values
// ****************************************************************
`define TKP_NUM_REGS 8
`define TKP_HALT_REG 3'h0
`define TKP_HALT_BIT 7
`define TKP_LOCK_REG 3'h7
`define TKP_LOCK_BIT 7
`define TKP_REG_RST 8'h00
`define TKP_WORD_W 11

`endif

// ===== rtl/tkp_pkg.sv
// Types used by the timekeeper three-wire port; its write buffer uses none of them.
// Assumes the configuration header is compiled alongside.
package tkp_pkg;

    // ****************************************************************
    // Transfer phases
    // ****************************************************************
    typedef enum logic [1:0] {
        TKP_CMD = 2'b00,
        TKP_WRITE = 2'b01,
        TKP_READ = 2'b10,
        TKP_DONE = 2'b11
    } tkp_phase_e;

endpackage : tkp_pkg

// ===== rtl/tkp_port.sv
// Three-wire serial access port of a clock/calendar timekeeper, with its register array.
// Assumes the three link pins arrive asynchronously and the shift clock is far slower
// than sys_clk; the timekeeping core takes buffered writes and may load registers itself.
`timescale 1ns/1ps
`include "tkp_cfg.svh"

module tkp_port #(
    parameter int NREGS = `TKP_NUM_REGS
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic transfer_enable,
    input wire logic sclk,
    input wire logic sio_in,
    output logic sio_out,
    output logic sio_oe,
    output logic [10:0] upd_data,
    output logic upd_valid,
    input wire logic upd_ready,
    output logic upd_overrun,
    input wire logic core_load,
    input wire logic [2:0] core_addr,
    input wire logic [7:0] core_data,
    output logic oscillator_halt_bit,
    output logic write_lock
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    if (NREGS != 8) begin : g_bad_regs
        $error("tkp_port: the three-bit register select serves exactly eight registers.");
    end

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [2:0] te_sync;
        logic [2:0] clk_sync;
        logic [1:0] din_sync;
        tkp_pkg::tkp_phase_e phase;
        logic [7:0] shift;
        logic [2:0] bit_cnt;
        logic [2:0] byte_idx;
        logic burst;
        logic [2:0] reg_sel;
        logic dout;
        logic oe;
        logic push;
        logic [10:0] word;
        logic overrun;
        logic [7:0][7:0] regs;
    } tkp_port_s;

    tkp_port_s st_ff;
    tkp_port_s nxt_st;
    logic te;
    logic rise;
    logic fall;
    logic din;
    logic [7:0] full_byte;
    logic lock;
    logic buf_ready;
    logic [10:0] pop_word;
    logic pop;

    // ****************************************************************
    // Pin sampling
    // ****************************************************************
    // Stage zero of each synchroniser feeds only stage one; edges are found between
    // stages one and two, so a metastable sample never reaches the decode.
    assign te = st_ff.te_sync[1];
    assign din = st_ff.din_sync[1];
    assign rise = st_ff.clk_sync[1] && !st_ff.clk_sync[2];
    assign fall = !st_ff.clk_sync[1] && st_ff.clk_sync[2];
    assign full_byte = {din, st_ff.shift[7:1]};
    assign lock = st_ff.regs[`TKP_LOCK_REG][`TKP_LOCK_BIT];
    assign pop = upd_valid && upd_ready;

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign sio_out = st_ff.dout;
    assign sio_oe = st_ff.oe;
    assign upd_data = pop_word;
    assign upd_overrun = st_ff.overrun;
    assign oscillator_halt_bit = st_ff.regs[`TKP_HALT_REG][`TKP_HALT_BIT];
    assign write_lock = lock;

    // Write words queue here so the core may stall for up to two words; a further byte is lost and flagged as an overrun.
    tkp_buf #(
        .W(`TKP_WORD_W)
    ) u_buf (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .in_valid(st_ff.push),
        .in_ready(buf_ready),
        .in_data(st_ff.word),
        .out_valid(upd_valid),
        .out_ready(upd_ready),
        .out_data(pop_word)
    );

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    // One process covers sampling, command decode, the data shifter and the array.
    always_comb begin
        nxt_st = st_ff;
        nxt_st.te_sync = {st_ff.te_sync[1:0], transfer_enable};
        nxt_st.clk_sync = {st_ff.clk_sync[1:0], sclk};
        nxt_st.din_sync = {st_ff.din_sync[0], sio_in};
        nxt_st.push = 1'b0;
        nxt_st.overrun = 1'b0;

        // A refused push shows as a one-cycle overrun pulse.
        if (st_ff.push && !buf_ready) begin
            nxt_st.overrun = 1'b1;
        end

        // Core loads first, so a drained serial write to the same register wins.
        if (core_load) begin
            nxt_st.regs[core_addr] = core_data;
        end
        if (pop) begin
            nxt_st.regs[pop_word[10:8]] = pop_word[7:0];
        end

        if (!te) begin
            nxt_st.phase = tkp_pkg::TKP_CMD;
            nxt_st.bit_cnt = 3'h0;
            nxt_st.byte_idx = 3'h0;
            nxt_st.burst = 1'b0;
            nxt_st.oe = 1'b0;
        end else begin
            case (st_ff.phase)
                tkp_pkg::TKP_CMD: begin
                    if (rise) begin
                        nxt_st.shift = full_byte;
                        nxt_st.bit_cnt = st_ff.bit_cnt + 3'h1;
                        if (st_ff.bit_cnt == 3'h7) begin
                            // Eighth bit completes the command byte.
                            nxt_st.bit_cnt = 3'h0;
                            if (full_byte[7:4] == `TKP_TEST_CODE && full_byte[`TKP_DIR_BIT]) begin
                                // Test read commands are not served; the rest of the transfer is ignored until transfer_enable drops.
                                nxt_st.phase = tkp_pkg::TKP_DONE;
                            end else begin
                                nxt_st.burst = (full_byte[7:1] == `TKP_BURST_CODE);
                                nxt_st.reg_sel = (full_byte[7:1] == `TKP_BURST_CODE)
                                    ? 3'h0 : full_byte[`TKP_ADDR_MSB:`TKP_ADDR_LSB];
                                nxt_st.phase = full_byte[`TKP_DIR_BIT]
                                    ? tkp_pkg::TKP_READ : tkp_pkg::TKP_WRITE;
                            end
                        end
                    end
                end
                tkp_pkg::TKP_WRITE: begin
                    if (rise) begin
                        nxt_st.shift = full_byte;
                        nxt_st.bit_cnt = st_ff.bit_cnt + 3'h1;
                        if (st_ff.bit_cnt == 3'h7) begin
                            nxt_st.word = {st_ff.reg_sel, full_byte};
                            // Locked writes are dropped except to the lock register itself,
                            // which a burst never touches.
                            nxt_st.push = (!lock || (!st_ff.burst
                                && st_ff.reg_sel == `TKP_LOCK_REG))
                                && !(st_ff.burst && st_ff.reg_sel == `TKP_LOCK_REG);
                            nxt_st.reg_sel = st_ff.reg_sel + 3'h1;
                            nxt_st.byte_idx = st_ff.byte_idx + 3'h1;
                            if (!st_ff.burst || st_ff.byte_idx == 3'h7) begin
                                nxt_st.phase = tkp_pkg::TKP_DONE;
                            end
                        end
                    end
                end
                tkp_pkg::TKP_READ: begin
                    if (fall) begin
                        // Drive the next bit, lowest first; a byte end moves to the
                        // next register in burst or repeats the same one otherwise.
                        nxt_st.dout = st_ff.regs[st_ff.reg_sel][st_ff.bit_cnt];
                        nxt_st.oe = 1'b1;
                        nxt_st.bit_cnt = st_ff.bit_cnt + 3'h1;
                        if (st_ff.bit_cnt == 3'h7 && st_ff.burst) begin
                            nxt_st.reg_sel = st_ff.reg_sel + 3'h1;
                        end
                    end
                end
                tkp_pkg::TKP_DONE: begin
                    // Further clocks are ignored until the enable drops.
                    nxt_st.phase = tkp_pkg::TKP_DONE;
                end
                default: begin
                    nxt_st.phase = tkp_pkg::TKP_DONE;
                end
            endcase
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    // Registers reset to a known value so the lock starts open and the halt bit clear.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            st_ff <= '0;
            st_ff.phase <= tkp_pkg::TKP_CMD;
            st_ff.regs <= {NREGS{`TKP_REG_RST}};
        end else begin
            st_ff <= nxt_st;
        end
    end

endmodule : tkp_port

// ===== testbench/tkp_host.sv
// Host model: drives enable, shift clock and the shared data line.
// Assumes sys_clk at 40 MHz; a shift clock period is eight cycles.
`timescale 1ns/1ps
module tkp_host (
    input wire logic sys_clk,
    input wire logic sio_out,
    input wire logic sio_oe,
    output logic transfer_enable,
    output logic sclk,
    output logic sio_in
);
    logic drv_ff;
    logic dat_ff;
    logic last_ff;
    initial begin
        transfer_enable = 1'b0;
        sclk = 1'b0;
        drv_ff = 1'b0;
        dat_ff = 1'b0;
        last_ff = 1'b0;
    end
    // A released line toggles, so stale data is never mistaken for a bit.
    assign sio_in = sio_oe ? sio_out : (drv_ff ? dat_ff : ~last_ff);
    always @(posedge sys_clk) begin
        last_ff <= sio_in;
    end
    // One frame: command, then n data clocks; read bits sampled late in high phase.
    task automatic frame(input logic [7:0] cmd, input int n, input logic [71:0] wd,
                         output logic [71:0] rd);
        logic [79:0] bits;
        bits = {wd, cmd};
        rd = '0;
        @(posedge sys_clk);
        transfer_enable <= 1'b1;
        repeat (4) @(posedge sys_clk);
        for (int i = 0; i < 8 + n; i++) begin
            sclk <= 1'b0;
            dat_ff <= bits[i];
            drv_ff <= (i < 8) || !cmd[0];
            repeat (4) @(posedge sys_clk);
            sclk <= 1'b1;
            repeat (4) @(posedge sys_clk);
            if (i >= 8) rd[i-8] = sio_in;
        end
        sclk <= 1'b0;
        transfer_enable <= 1'b0;
        drv_ff <= 1'b0;
        repeat (8) @(posedge sys_clk);
    endtask : frame
endmodule : tkp_host

// ===== testbench/tkp_port_sva.sv
// Checker for the three-wire port: pin timing and the update group.
// Assumes it is bound onto tkp_port and sees only that module's ports.
`timescale 1ns/1ps
module tkp_port_sva #(
    parameter int NREGS = 8
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic transfer_enable,
    input wire logic sclk,
    input wire logic sio_in,
    input wire logic sio_out,
    input wire logic sio_oe,
    input wire logic [10:0] upd_data,
    input wire logic upd_valid,
    input wire logic upd_ready,
    input wire logic upd_overrun,
    input wire logic core_load,
    input wire logic [2:0] core_addr,
    input wire logic [7:0] core_data,
    input wire logic oscillator_halt_bit,
    input wire logic write_lock
);
    // ********************
    // Properties
    // ********************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    property p_oe_idle; (!transfer_enable) [*5] |-> !sio_oe; endproperty
    property p_oe_rise; $rose(sio_oe) |-> transfer_enable && !$past(sclk, 2); endproperty
    property p_out_fall; sio_oe && $changed(sio_out) |-> !$past(sclk, 2); endproperty
    // Pin phases last four cycles, so a bit never moves late in a high phase.
    property p_out_hold; sclk [*4] |-> $stable(sio_out); endproperty
    property p_oe_fall; $fell(sio_oe) |-> !$past(transfer_enable, 2); endproperty
    property p_upd_hold; upd_valid && !upd_ready |=> upd_valid && $stable(upd_data); endproperty
    // A word leaves the shifter three cycles after the pin rise, so the enable pin may
    // already be low when it shows; what counts is the enable as the decode saw it.
    property p_upd_rise; $rose(upd_valid) |-> $past(transfer_enable, 4); endproperty
    property p_ovr; upd_overrun |-> $past(upd_valid); endproperty
    property p_reg_hold;
        !(upd_valid && upd_ready) && !core_load |=> $stable(write_lock) && $stable(oscillator_halt_bit);
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("driver on, enable low");
    a_oe_rise: assert property (p_oe_rise) else $error("driver on off fall");
    a_out_fall: assert property (p_out_fall) else $error("bit moved off fall");
    a_out_hold: assert property (p_out_hold) else $error("bit moved, clock high");
    a_oe_fall: assert property (p_oe_fall) else $error("driver off, enable high");
    a_upd_hold: assert property (p_upd_hold) else $error("word dropped");
    a_upd_rise: assert property (p_upd_rise) else $error("word out of frame");
    a_ovr: assert property (p_ovr) else $error("overrun, buffer empty");
    a_reg_hold: assert property (p_reg_hold) else $error("register moved");
    c_write: cover property (upd_valid && upd_ready);
    c_read: cover property ($rose(sio_oe));
    c_ovr: cover property (upd_overrun);
endmodule : tkp_port_sva

// ===== testbench/tkp_port_tb.sv
// Self-checking bench for the three-wire port with a host model.
// Assumes the checker and host files are compiled first.
`timescale 1ns/1ps
module tkp_port_tb;
    logic sys_clk, rstn, te, sclk, sio_in, sio_out, sio_oe;
    logic upd_valid, upd_ready, upd_overrun, core_load, halt, lock;
    logic [10:0] upd_data;
    logic [2:0] core_addr;
    logic [7:0] core_data;
    logic [71:0] rd;
    logic [10:0] words[$];
    int err_total, total_checks, ovr, oe_cnt, oe_base;
    tkp_port uut (.sys_clk(sys_clk), .rstn(rstn), .transfer_enable(te), .sclk(sclk),
        .sio_in(sio_in), .sio_out(sio_out), .sio_oe(sio_oe), .upd_data(upd_data),
        .upd_valid(upd_valid), .upd_ready(upd_ready), .upd_overrun(upd_overrun),
        .core_load(core_load), .core_addr(core_addr), .core_data(core_data),
        .oscillator_halt_bit(halt), .write_lock(lock));
    tkp_host h (.sys_clk(sys_clk), .sio_out(sio_out), .sio_oe(sio_oe),
        .transfer_enable(te), .sclk(sclk), .sio_in(sio_in));
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // Collects every accepted update word and counts every lost one.
    always @(posedge sys_clk) begin
        if (upd_valid === 1'b1 && upd_ready === 1'b1) words.push_back(upd_data);
        if (upd_overrun === 1'b1) ovr++;
        if (sio_oe === 1'b1) oe_cnt++;
    end
    task automatic chk(input string what, input logic [71:0] exp, input logic [71:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("checks %0d, errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    // The full sequence takes about 2900 cycles; this cuts a hang short.
    initial begin
        repeat (40000) @(posedge sys_clk);
        err_total++;
        tally_and_finish();
    end
    // ********************
    // Tests
    // ********************
    initial begin
        rstn = 1'b0;
        upd_ready = 1'b1;
        core_load = 1'b0;
        core_addr = 3'h0;
        core_data = 8'h00;
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk("reset state", 3'h0, {halt, lock, sio_oe});
        h.frame(8'h8E, 8, 72'h00, rd);
        h.frame(8'h80, 8, 72'h00, rd);
        words.delete();
        h.frame(8'h84, 16, 72'hFFA5, rd);
        chk("single word", {32'h1, 11'h2A5}, {words.size(), words[0]});
        h.frame(8'h85, 16, 72'h00, rd);
        chk("single read", 16'hA5A5, rd[15:0]);
        @(posedge sys_clk);
        core_load <= 1'b1;
        core_addr <= 3'h4;
        core_data <= 8'h44;
        @(posedge sys_clk);
        core_load <= 1'b0;
        words.delete();
        h.frame(8'h86, 4, 72'hF, rd);
        h.frame(8'h87, 8, 72'h00, rd);
        chk("aborted write", {32'h0, 8'h00}, {words.size(), rd[7:0]});
        upd_ready <= 1'b0;
        words.delete();
        h.frame(8'hBE, 64, 72'h007766554433221180, rd);
        upd_ready <= 1'b1;
        repeat (4) @(posedge sys_clk);
        chk("overrun seen", 1'b1, ovr > 0);
        chk("burst words", {32'h2, 11'h111, 11'h080}, {words.size(), words[1], words[0]});
        chk("halt bit", 1'b1, halt);
        h.frame(8'hBF, 72, 72'h00, rd);
        chk("burst read", 72'h80000000440_0A51180, rd);
        h.frame(8'h8E, 8, 72'h80, rd);
        chk("lock set", 1'b1, lock);
        h.frame(8'h82, 8, 72'h5A, rd);
        h.frame(8'h83, 8, 72'h00, rd);
        chk("locked write", 8'h11, rd[7:0]);
        h.frame(8'h8E, 8, 72'h00, rd);
        chk("lock clear", 1'b0, lock);
        // A test command must never turn the data driver on.
        oe_base = oe_cnt;
        h.frame(8'h93, 8, 72'h00, rd);
        chk("test command", 32'h0, oe_cnt - oe_base);
        tally_and_finish();
    end
endmodule : tkp_port_tb
bind tkp_port tkp_port_sva #(.NREGS(NREGS)) u_sva (.sys_clk(sys_clk), .rstn(rstn),
    .transfer_enable(transfer_enable), .sclk(sclk), .sio_in(sio_in), .sio_out(sio_out),
    .sio_oe(sio_oe), .upd_data(upd_data), .upd_valid(upd_valid), .upd_ready(upd_ready),
    .upd_overrun(upd_overrun), .core_load(core_load), .core_addr(core_addr),
    .core_data(core_data), .oscillator_halt_bit(oscillator_halt_bit),
    .write_lock(write_lock));
